// *** design/tai_regs_pkg.sv ***
package tai_regs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int RSSI_W = 7;
	localparam int USER_W = 5;
	localparam int TEST_W = 7;

	// =====================================================
	// Register offsets.
	localparam logic [4:0] OFF_RSSI_LIMIT = 5'h1c;
	localparam logic [4:0] OFF_USER_PIN   = 5'h1d;
	localparam logic [4:0] OFF_TEST_DUMMY = 5'h1e;
	localparam logic [4:0] OFF_TEST_CMD   = 5'h1f;

	// =====================================================
	// Field positions.
	localparam int BIT_FLAG  = 7;
	localparam int BIT_USER7 = 7;

	// =====================================================
	// Values after reset.
	localparam logic [6:0] FLOOR_RESET     = 7'h00;
	localparam logic [6:0] TEST_CMD_RESET  = 7'h00;
	localparam logic [4:0] USER_DATA_RESET = 5'h00;
	localparam logic       USER7_RESET     = 1'b0;
	localparam logic [7:0] RDATA_RESET     = 8'h00;

	// =====================================================
	// Comparison of a converted value against the floor.
	function automatic logic at_or_above(input logic [6:0] value, input logic [6:0] floor);
		return value >= floor;
	endfunction
endpackage

// *** design/rssi_limit_cmp.sv ***
`timescale 1ns/100ps
module rssi_limit_cmp
	import tai_regs_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wr_i,
	input  wire logic [tai_regs_pkg::RSSI_W-1:0] wdata_i,
	input  wire logic [tai_regs_pkg::RSSI_W-1:0] rssi_i,
	output logic      [tai_regs_pkg::RSSI_W-1:0] floor_o,
	output logic                               flag_o
);
	typedef struct packed {
		logic [RSSI_W-1:0] floor;
		logic              flag;
	} cmp_s;

	cmp_s state;
	cmp_s next_state;

	// =====================================================
	// Floor register and comparison.
	always_comb begin
		next_state = state;
		if (wr_i) begin
			next_state.floor = wdata_i;
		end
		next_state.flag = at_or_above(rssi_i, state.floor);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '{floor: FLOOR_RESET, flag: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign floor_o = state.floor;
	assign flag_o  = state.flag;

	// =====================================================
	// Checks.
	property p_flag_set;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && at_or_above(rssi_i, floor_o) |=> flag_o;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("Flag not set at or above floor.");

	property p_flag_clr;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && !at_or_above(rssi_i, floor_o) |=> !flag_o;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("Flag not cleared below floor.");

	property p_floor_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_i |=> floor_o == $past(wdata_i);
	endproperty
	a_floor_write: assert property (p_floor_write) else $error("Floor not written.");

	property p_floor_reset;
		@(posedge clk_i)
		rst_i |=> floor_o == FLOOR_RESET && !flag_o;
	endproperty
	a_floor_reset: assert property (p_floor_reset) else $error("Floor not reset.");
endmodule

// *** design/user_pin_port.sv ***
`timescale 1ns/100ps
module user_pin_port
	import tai_regs_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wr_i,
	input  wire logic [tai_regs_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                          pcmcia_i,
	input  wire logic [tai_regs_pkg::USER_W-1:0] user_en_i,
	input  wire logic                          user7_en_i,
	output logic      [tai_regs_pkg::USER_W-1:0] pin_o,
	output logic      [tai_regs_pkg::USER_W-1:0] pin_oe_o,
	output logic                               pin7_o,
	output logic                               pin7_oe_o
);
	typedef struct packed {
		logic [USER_W-1:0] values;
		logic              user7_bit;
		logic [USER_W-1:0] pin;
		logic [USER_W-1:0] pin_oe;
		logic              pin7;
		logic              pin7_oe;
	} pins_s;

	pins_s state;
	pins_s next_state;

	// =====================================================
	// Written values and pin drive.
	always_comb begin
		next_state = state;
		if (wr_i) begin
			next_state.values    = wdata_i[USER_W-1:0];
			next_state.user7_bit = wdata_i[BIT_USER7];
		end
		next_state.pin     = next_state.values;
		next_state.pin_oe  = user_en_i & {USER_W{pcmcia_i}};
		next_state.pin7    = ~next_state.user7_bit;
		next_state.pin7_oe = pcmcia_i & user7_en_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '{USER_DATA_RESET, USER7_RESET, USER_DATA_RESET, 5'h00, ~USER7_RESET, 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign pin_o     = state.pin;
	assign pin_oe_o  = state.pin_oe;
	assign pin7_o    = state.pin7;
	assign pin7_oe_o = state.pin7_oe;

	// =====================================================
	// Checks.
	logic                w7;
	logic [USER_W-1:0] wd5;
	logic [USER_W-1:0] mask;
	assign w7   = wdata_i[BIT_USER7];
	assign wd5  = wdata_i[USER_W-1:0];
	assign mask = user_en_i & {USER_W{pcmcia_i}};

	property p_user7_drive;
		@(posedge clk_i) disable iff (rst_i)
		wr_i && pcmcia_i && user7_en_i |=> pin7_oe_o && pin7_o == ~$past(w7);
	endproperty
	a_user7_drive: assert property (p_user7_drive) else $error("User7 not driven inverted.");

	property p_user7_idle;
		@(posedge clk_i) disable iff (rst_i)
		!(pcmcia_i && user7_en_i) |=> !pin7_oe_o;
	endproperty
	a_user7_idle: assert property (p_user7_idle) else $error("User7 driven when not enabled.");

	property p_user_drive;
		@(posedge clk_i) disable iff (rst_i)
		wr_i |=> pin_oe_o == $past(mask) && (pin_o & pin_oe_o) == ($past(wd5) & $past(mask));
	endproperty
	a_user_drive: assert property (p_user_drive) else $error("User pin drive mismatch.");
endmodule

// *** design/rssi_user_regs.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Flag bit 7 reads one when converted RSSI is at or above the floor.
// - Flag bit 7 reads zero when converted RSSI is below the floor.
// - Seven-bit floor resets to zero; at-or-above result goes to channel assessment.
// - User7 pin takes the inverted written bit in PCMCIA mode with its enable set.
// - Otherwise writes to the user7 bit leave the user7 pin alone.
// - Reading the user7 bit returns the inverted live user7 pin level.
// - Each user value bit drives its pin when its enable and strap are one.
// - Reading the user value field returns the live user pin levels.
// - Bits 6 and 5 of the user register are written zero; reads undefined.
// - The dummy register is all reserved; written zero, read undefined.
// - The seven-bit test command resets to zero and selects a test mode.
// - The compared value is the seven-bit converter result.
module rssi_user_regs (
	input  wire logic                            CLK_SYS_I,
	input  wire logic                            RESET_I,
	input  wire logic [tai_regs_pkg::ADDR_W-1:0] REG_ADDR_I,
	input  wire logic                            REG_WR_I,
	input  wire logic                            REG_RD_I,
	input  wire logic [tai_regs_pkg::DATA_W-1:0] REG_WDATA_I,
	output logic      [tai_regs_pkg::DATA_W-1:0] REG_RDATA_O,
	output logic                                 REG_RVALID_O,
	input  wire logic [tai_regs_pkg::RSSI_W-1:0] RSSI_VALUE_I,
	output logic                                 CCA_ABOVE_O,
	input  wire logic                            PCMCIA_MODE_I,
	input  wire logic [tai_regs_pkg::USER_W-1:0] USER_PIN_DRIVE_ENABLE_I,
	input  wire logic                            USER7_DRIVE_ENABLE_I,
	input  wire logic [tai_regs_pkg::USER_W-1:0] USER_PIN_I,
	output logic      [tai_regs_pkg::USER_W-1:0] USER_PIN_O,
	output logic      [tai_regs_pkg::USER_W-1:0] USER_PIN_OE_O,
	input  wire logic                            USER7_PIN_I,
	output logic                                 USER7_PIN_O,
	output logic                                 USER7_PIN_OE_O,
	output logic      [tai_regs_pkg::TEST_W-1:0] TEST_MODE_O,
	output logic                                 TEST_ACTIVE_O
);
	import tai_regs_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic [TEST_W-1:0] test_cmd;
		logic              test_active;
	} regs_s;

	regs_s             state;
	regs_s             next_state;
	logic              wr_limit;
	logic              wr_user;
	logic              wr_cmd;
	logic [RSSI_W-1:0] floor;
	logic              flag;

	// =====================================================
	// Address decode.
	assign wr_limit = REG_WR_I && (REG_ADDR_I == OFF_RSSI_LIMIT);
	assign wr_user  = REG_WR_I && (REG_ADDR_I == OFF_USER_PIN);
	assign wr_cmd   = REG_WR_I && (REG_ADDR_I == OFF_TEST_CMD);

	// =====================================================
	// Floor register and comparator.
	rssi_limit_cmp u_cmp (
		.clk_i   (CLK_SYS_I),
		.rst_i   (RESET_I),
		.wr_i    (wr_limit),
		.wdata_i (REG_WDATA_I[RSSI_W-1:0]),
		.rssi_i  (RSSI_VALUE_I),
		.floor_o (floor),
		.flag_o  (flag)
	);

	// =====================================================
	// User pin drive.
	user_pin_port u_pins (
		.clk_i      (CLK_SYS_I),
		.rst_i      (RESET_I),
		.wr_i       (wr_user),
		.wdata_i    (REG_WDATA_I),
		.pcmcia_i   (PCMCIA_MODE_I),
		.user_en_i  (USER_PIN_DRIVE_ENABLE_I),
		.user7_en_i (USER7_DRIVE_ENABLE_I),
		.pin_o      (USER_PIN_O),
		.pin_oe_o   (USER_PIN_OE_O),
		.pin7_o     (USER7_PIN_O),
		.pin7_oe_o  (USER7_PIN_OE_O)
	);

	// =====================================================
	// Read answer and test command register.
	always_comb begin
		next_state = state;
		next_state.rvalid = REG_RD_I;
		next_state.rdata = RDATA_RESET;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				OFF_RSSI_LIMIT: begin
					next_state.rdata = {flag, floor};
				end
				OFF_USER_PIN: begin
					next_state.rdata = {~USER7_PIN_I, 2'b00, USER_PIN_I};
				end
				OFF_TEST_CMD: begin
					next_state.rdata = {1'b0, state.test_cmd};
				end
				default: begin
					next_state.rdata = RDATA_RESET;
				end
			endcase
		end
		if (wr_cmd) begin
			next_state.test_cmd = REG_WDATA_I[TEST_W-1:0];
		end
		next_state.test_active = |next_state.test_cmd;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			state <= '{RDATA_RESET, 1'b0, TEST_CMD_RESET, 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// =====================================================
	// Outputs.
	assign REG_RDATA_O   = state.rdata;
	assign REG_RVALID_O  = state.rvalid;
	assign CCA_ABOVE_O   = flag;
	assign TEST_MODE_O   = state.test_cmd;
	assign TEST_ACTIVE_O = state.test_active;

	// =====================================================
	// Checks.
	logic [TEST_W-1:0] wcmd;
	assign wcmd = REG_WDATA_I[TEST_W-1:0];

	sequence s_rd_user;
		REG_RD_I && REG_ADDR_I == OFF_USER_PIN;
	endsequence

	sequence s_rd_limit;
		REG_RD_I && REG_ADDR_I == OFF_RSSI_LIMIT;
	endsequence

	sequence s_rd_dummy;
		REG_RD_I && REG_ADDR_I == OFF_TEST_DUMMY;
	endsequence

	sequence s_cmd_wr;
		REG_WR_I && REG_ADDR_I == OFF_TEST_CMD;
	endsequence

	sequence s_no_cmd_wr;
		!(REG_WR_I && REG_ADDR_I == OFF_TEST_CMD);
	endsequence

	property p_user7_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_user |=> REG_RVALID_O && REG_RDATA_O[BIT_USER7] == ~$past(USER7_PIN_I);
	endproperty
	a_user7_read: assert property (p_user7_read) else $error("User7 read not inverted pin.");

	property p_user_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_user |=> REG_RDATA_O[USER_W-1:0] == $past(USER_PIN_I);
	endproperty
	a_user_read: assert property (p_user_read) else $error("User read not live pins.");

	property p_user_rsvd;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_user |=> REG_RDATA_O[6:5] == 2'b00;
	endproperty
	a_user_rsvd: assert property (p_user_rsvd) else $error("Reserved user bits not zero.");

	property p_dummy_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_dummy |=> REG_RVALID_O && REG_RDATA_O == RDATA_RESET;
	endproperty
	a_dummy_read: assert property (p_dummy_read) else $error("Dummy read not zero.");

	property p_limit_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_limit |=> REG_RDATA_O == {$past(flag), $past(floor)};
	endproperty
	a_limit_read: assert property (p_limit_read) else $error("Limit read mismatch.");

	property p_cca_follow;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && at_or_above(RSSI_VALUE_I, floor) ##1 at_or_above(RSSI_VALUE_I, floor)
			|-> CCA_ABOVE_O ##1 CCA_ABOVE_O;
	endproperty
	a_cca_follow: assert property (p_cca_follow) else $error("Assessment signal lost.");

	property p_cmd_write;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_cmd_wr |=> TEST_MODE_O == $past(wcmd) && TEST_ACTIVE_O == |$past(wcmd);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("Test command not taken.");

	property p_cmd_hold;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_no_cmd_wr |=> $stable(TEST_MODE_O);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("Test command changed unwritten.");

	property p_cmd_reset;
		@(posedge CLK_SYS_I)
		RESET_I |=> TEST_MODE_O == TEST_CMD_RESET && !TEST_ACTIVE_O && !REG_RVALID_O;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset) else $error("Test command not reset.");

	property p_rvalid;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == RDATA_RESET;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("Read answer without request.");

	logic [USER_W-1:0] oe_mask;
	logic              drive7;
	logic              w_user7;
	assign oe_mask = USER_PIN_DRIVE_ENABLE_I & {USER_W{PCMCIA_MODE_I}};
	assign drive7  = PCMCIA_MODE_I & USER7_DRIVE_ENABLE_I;
	assign w_user7 = REG_WDATA_I[BIT_USER7];

	sequence s_rd_cmd;
		REG_RD_I && REG_ADDR_I == OFF_TEST_CMD;
	endsequence

	property p_cca_set;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && at_or_above(RSSI_VALUE_I, floor) |=> CCA_ABOVE_O;
	endproperty
	a_cca_set: assert property (p_cca_set) else $error("Assessment signal not set.");

	property p_cca_clr;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && !at_or_above(RSSI_VALUE_I, floor) |=> !CCA_ABOVE_O;
	endproperty
	a_cca_clr: assert property (p_cca_clr) else $error("Assessment signal not cleared.");

	property p_flag_ro;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && wr_limit && REG_WDATA_I[BIT_FLAG] && !at_or_above(RSSI_VALUE_I, floor)
			|=> !CCA_ABOVE_O;
	endproperty
	a_flag_ro: assert property (p_flag_ro) else $error("Flag taken from a write.");

	property p_floor_hold;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && !wr_limit |=> $stable(floor);
	endproperty
	a_floor_hold: assert property (p_floor_hold) else $error("Floor changed unwritten.");

	property p_rd_answer;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && REG_RD_I |=> REG_RVALID_O;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("Read not answered.");

	property p_cmd_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		s_rd_cmd |=> REG_RDATA_O == {1'b0, $past(TEST_MODE_O)};
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("Test command read mismatch.");

	property p_unmapped_read;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && REG_RD_I && REG_ADDR_I < OFF_RSSI_LIMIT
			|=> REG_RVALID_O && REG_RDATA_O == RDATA_RESET;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

	property p_active_match;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		TEST_ACTIVE_O == (|TEST_MODE_O);
	endproperty
	a_active_match: assert property (p_active_match) else $error("Test active mismatch.");

	property p_user_oe;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I |=> USER_PIN_OE_O == $past(oe_mask);
	endproperty
	a_user_oe: assert property (p_user_oe) else $error("User pin enable mismatch.");

	property p_user7_oe;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I |=> USER7_PIN_OE_O == $past(drive7);
	endproperty
	a_user7_oe: assert property (p_user7_oe) else $error("User7 enable mismatch.");

	property p_user_hold;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && !wr_user |=> $stable(USER_PIN_O);
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("User value changed unwritten.");

	property p_user7_hold;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && !wr_user |=> $stable(USER7_PIN_O);
	endproperty
	a_user7_hold: assert property (p_user7_hold) else $error("User7 changed unwritten.");

	property p_user7_value;
		@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RESET_I && wr_user |=> USER7_PIN_O == ~$past(w_user7);
	endproperty
	a_user7_value: assert property (p_user7_value) else $error("User7 value not inverted.");
endmodule

// *** tb/pin_partner.sv ***
`timescale 1ns/100ps
// =====================================================
// Converter and user pin side of the register block.
module pin_partner (
	input  wire logic       clk_i,
	input  wire logic [6:0] rssi_req_i,
	output logic      [6:0] rssi_o,
	input  wire logic [4:0] pin_i,
	input  wire logic [4:0] pin_oe_i,
	input  wire logic [4:0] ext_i,
	input  wire logic       pin7_i,
	input  wire logic       pin7_oe_i,
	input  wire logic       ext7_i,
	output logic      [4:0] level_o,
	output logic            level7_o
);
	// The converter delivers a seven-bit result once per clock.
	always_ff @(posedge clk_i) begin
		rssi_o <= rssi_req_i;
	end

	// A pin shows the device's value while driven, else the outside level.
	assign level_o  = (pin_i & pin_oe_i) | (ext_i & ~pin_oe_i);
	assign level7_o = pin7_oe_i ? pin7_i : ext7_i;
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import tai_regs_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       rvalid;
	logic [6:0] rssi_req = 7'h00;
	logic [6:0] rssi;
	logic       cca;
	logic       pcm = 1'b0;
	logic [4:0] uen = 5'h00;
	logic       u7en = 1'b0;
	logic [4:0] ext = 5'h00;
	logic       ext7 = 1'b0;
	logic [4:0] lvl;
	logic [4:0] pin_o;
	logic [4:0] pin_oe;
	logic       lvl7;
	logic       pin7_o;
	logic       pin7_oe;
	logic [6:0] tmode;
	logic       tact;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         seed = 14;

	always #4 clk = ~clk;

	rssi_user_regs i_rssi_user_regs (
		.CLK_SYS_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
		.RSSI_VALUE_I(rssi), .CCA_ABOVE_O(cca), .PCMCIA_MODE_I(pcm),
		.USER_PIN_DRIVE_ENABLE_I(uen), .USER7_DRIVE_ENABLE_I(u7en), .USER_PIN_I(lvl),
		.USER_PIN_O(pin_o), .USER_PIN_OE_O(pin_oe), .USER7_PIN_I(lvl7),
		.USER7_PIN_O(pin7_o), .USER7_PIN_OE_O(pin7_oe), .TEST_MODE_O(tmode),
		.TEST_ACTIVE_O(tact)
	);

	pin_partner i_pin_partner (
		.clk_i(clk), .rssi_req_i(rssi_req), .rssi_o(rssi), .pin_i(pin_o), .pin_oe_i(pin_oe),
		.ext_i(ext), .pin7_i(pin7_o), .pin7_oe_i(pin7_oe), .ext7_i(ext7), .level_o(lvl),
		.level7_o(lvl7)
	);

	// =====================================================
	// Shared tasks.
	task automatic end_sim;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({7'h00, rvalid}, 8'h01);
		d = rdata;
	endtask

	// =====================================================
	// Main sequence.
	initial begin
		logic [7:0] d;
		int         v;
		int         fl;
		logic [4:0] mask;
		logic [4:0] exp_lvl;
		logic       drv7;
		logic       exp7;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_reg(OFF_RSSI_LIMIT, d);
		chk(d, 8'h80);
		rd_reg(OFF_TEST_CMD, d);
		chk(d, 8'h00);
		for (int i = 0; i < 40; i++) begin
			fl = (i == 2) ? 127 : ($random(seed) & 127);
			v = (i < 8) ? fl - (i % 2) : ($random(seed) & 127);
			if (v < 0) begin
				v = 0;
			end
			wr_reg(OFF_RSSI_LIMIT, 8'h80 | 8'(fl));
			rssi_req <= 7'(v);
			idle(3);
			chk({7'h00, cca}, {7'h00, 1'(v >= fl)});
			rd_reg(OFF_RSSI_LIMIT, d);
			chk(d, {1'(v >= fl), 7'(fl)});
		end
		wr_reg(5'h00, 8'h55);
		rd_reg(5'h00, d);
		chk(d, 8'h00);
		rd_reg(OFF_RSSI_LIMIT, d);
		chk(d, {1'(v >= fl), 7'(fl)});
		wr_reg(OFF_TEST_DUMMY, 8'h00);
		rd_reg(OFF_TEST_DUMMY, d);
		chk(d, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 0 : (i == 1) ? 127 : ($random(seed) & 127);
			wr_reg(OFF_TEST_CMD, 8'(v));
			idle(1);
			chk({1'b0, tmode}, 8'(v));
			chk({7'h00, tact}, {7'h00, 1'(v != 0)});
			rd_reg(OFF_TEST_CMD, d);
			chk(d, 8'(v));
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({1'b0, tmode}, {1'b0, TEST_CMD_RESET});
		chk({7'h00, tact}, 8'h00);
		rd_reg(OFF_RSSI_LIMIT, d);
		chk(d, {1'b1, FLOOR_RESET});
		wr_reg(OFF_TEST_CMD, 8'h00);
		for (int i = 0; i < 24; i++) begin
			v = $random(seed);
			@(posedge clk);
			pcm <= v[25] | i[0];
			u7en <= v[26] | i[1];
			uen <= v[12:8];
			ext <= v[20:16];
			ext7 <= v[24];
			wr_reg(OFF_USER_PIN, 8'(v) & 8'h9f);
			idle(2);
			mask = pcm ? uen : 5'h00;
			exp_lvl = (v[4:0] & mask) | (ext & ~mask);
			drv7 = pcm & u7en;
			exp7 = drv7 ? ~v[7] : ext7;
			chk({3'h0, pin_oe}, {3'h0, mask});
			chk({3'h0, lvl}, {3'h0, exp_lvl});
			chk({6'h00, pin7_oe, lvl7}, {6'h00, drv7, exp7});
			rd_reg(OFF_USER_PIN, d);
			chk(d & 8'h9f, {~exp7, 2'b00, exp_lvl});
		end
		end_sim;
	end

	// =====================================================
	// Watchdog against a hang.
	initial begin
		#50000;
		error_cnt++;
		end_sim;
	end
endmodule
